// ### rtl/dual_comparator_control.sv
/*
 * Control and status logic for two analog comparators: control
 * registers, status, event flags, interrupt and pin routing.
 * Assumes the analog cores drive comparator_result asynchronously
 * (high when the non-inverting input is above the inverting one) and
 * that a register master follows the one-cycle strobe protocol.
 */
// Added by the designer: the address-and-strobe port.
//
// Overview of operation
// - two channels, each with own control register
// - bit 7 switches comparator on or off
// - bit 6 routes result to output pin
// - bit 5 inverts result everywhere downstream
// - event code 11 any change, 00 none
// - code 10 falling only, 01 rising only
// - selecting any-change mode sets the flag
// - bit 2 picks programmable reference or pin
// - code 11 fixed reference, 00 own pin
// - code 10 second pin on first only
// - status read-only, bits 1-0 both results
// - core result high when positive input higher
// - inverted status reads one when below
// - flag sticky until cleared, write sets
// - flags set regardless of enables
`timescale 1ns/1ns
module dual_comparator_control import comparator_pkg::*; (
   input wire logic core_clk,
   input wire logic resetn,
   input bus_req_type bus_req,
   output logic [DATA_W-1:0] rdata,
   input wire logic [NUM_CH-1:0] comparator_result,
   output analog_sel_type [NUM_CH-1:0] analog_sel,
   output logic [NUM_CH-1:0] result_output_pin,
   output logic [NUM_CH-1:0] result_to_pin_enable,
   output logic irq
);

   // ****************************************
   // declarations
   // ****************************************
   ctrl_type ctrl_reg [NUM_CH];
   ctrl_type ctrl_next [NUM_CH];
   ctrl_type wr_ctrl;
   logic [NUM_CH-1:0] ctrl_hit;
   logic status_hit;
   logic flag_hit;
   logic enable_hit;
   logic [NUM_CH-1:0] synced;
   logic [NUM_CH-1:0] adjusted;
   logic [NUM_CH-1:0] event_pulse;
   logic [NUM_CH-1:0] auto_set;
   logic [NUM_CH-1:0] flag_reg;
   logic [NUM_CH-1:0] flag_next;
   logic [NUM_CH-1:0] enable_reg;
   logic [NUM_CH-1:0] enable_next;
   logic [NUM_CH-1:0] pin_reg;
   logic [NUM_CH-1:0] pin_next;
   logic [NUM_CH-1:0] pin_en_reg;
   logic [NUM_CH-1:0] pin_en_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;

   // ****************************************
   // address decode
   // ****************************************
   assign ctrl_hit[0] = bus_req.addr == CTRL_FIRST_OFFSET;
   assign ctrl_hit[1] = bus_req.addr == CTRL_SECOND_OFFSET;
   assign status_hit = bus_req.addr == STATUS_OFFSET;
   assign flag_hit = bus_req.addr == FLAG_OFFSET;
   assign enable_hit = bus_req.addr == ENABLE_OFFSET;
   assign wr_ctrl = ctrl_type'(bus_req.wdata);

   // ****************************************
   // result path
   // ****************************************
   // raw core results into the clock domain
   result_sync #(
      .WIDTH(NUM_CH)
   ) u_sync (
      .core_clk(core_clk),
      .resetn(resetn),
      .async_in(comparator_result),
      .sync_out(synced)
   );

   // inverting input route per channel
   function automatic neg_route_type neg_route(input neg_code_type code, input logic first);
      neg_route = ROUTE_OPEN;
      unique case (code)
         NEG_OWN_PIN: neg_route = ROUTE_OWN_PIN;
         NEG_RESERVED: neg_route = ROUTE_OPEN;
         NEG_SECOND_PIN: neg_route = first ? ROUTE_SECOND_PIN : ROUTE_OPEN;
         NEG_FIXED_REF: neg_route = ROUTE_FIXED_REF;
      endcase
   endfunction

   // one slice per channel; only the first can route the second pin
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++)
      begin : g_ch
         channel_event u_event (
            .core_clk(core_clk),
            .resetn(resetn),
            .synced_result(synced[ch]),
            .result_invert(ctrl_reg[ch].result_invert),
            .event_edge_select(ctrl_reg[ch].event_edge_select),
            .adjusted_result(adjusted[ch]),
            .event_pulse(event_pulse[ch])
         );
         // entering any-change mode raises the flag
         assign auto_set[ch] = bus_req.wr && ctrl_hit[ch] &&
            wr_ctrl.event_edge_select == EDGE_ANY &&
            ctrl_reg[ch].event_edge_select != EDGE_ANY;
         // analog mux selects decoded from the control register
         assign analog_sel[ch].comparator_on = ctrl_reg[ch].comparator_on;
         assign analog_sel[ch].positive_input_select =
            ctrl_reg[ch].positive_input_select;
         assign analog_sel[ch].negative_input_select =
            neg_route(ctrl_reg[ch].negative_input_select, ch == 0);
      end
   endgenerate

   // ****************************************
   // control registers
   // ****************************************
   // each channel written only at its own offset
   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
      begin
         ctrl_next[i] = ctrl_reg[i];
         if (bus_req.wr && ctrl_hit[i])
            ctrl_next[i] = wr_ctrl;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < NUM_CH; i++)
            ctrl_reg[i] <= ctrl_type'(CTRL_RESET);
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
            ctrl_reg[i] <= ctrl_next[i];
      end
   end

   // ****************************************
   // event flags and enables
   // ****************************************
   // set beats clear; read or write of zero clears
   always_comb
   begin
      enable_next = enable_reg;
      if (bus_req.wr && enable_hit)
         enable_next = bus_req.wdata[NUM_CH-1:0];
      flag_next = flag_reg;
      for (int i = 0; i < NUM_CH; i++)
      begin
         if ((bus_req.rd && flag_hit) || (bus_req.wr && flag_hit && !bus_req.wdata[i]))
            flag_next[i] = 1'b0;
         if (event_pulse[i] || auto_set[i] || (bus_req.wr && flag_hit && bus_req.wdata[i]))
            flag_next[i] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flag_reg <= '0;
         enable_reg <= '0;
      end
      else
      begin
         flag_reg <= flag_next;
         enable_reg <= enable_next;
      end
   end

   // enables gate only the request line
   assign irq = |(flag_reg & enable_reg);

   // ****************************************
   // pin outputs
   // ****************************************
   // result reaches the pin only when routed
   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
      begin
         pin_en_next[i] = ctrl_reg[i].result_to_pin_enable;
         pin_next[i] = ctrl_reg[i].result_to_pin_enable & adjusted[i];
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_reg <= '0;
         pin_en_reg <= '0;
      end
      else
      begin
         pin_reg <= pin_next;
         pin_en_reg <= pin_en_next;
      end
   end

   assign result_output_pin = pin_reg;
   assign result_to_pin_enable = pin_en_reg;

   // ****************************************
   // read data
   // ****************************************
   // data valid only in the cycle after the strobe
   always_comb
   begin
      rdata_next = 8'h00;
      if (bus_req.rd)
      begin
         if (status_hit)
            rdata_next = {{(DATA_W-NUM_CH){1'b0}}, adjusted};
         else if (ctrl_hit[0])
            rdata_next = ctrl_reg[0];
         else if (ctrl_hit[1])
            rdata_next = ctrl_reg[1];
         else if (flag_hit)
            rdata_next = {{(DATA_W-NUM_CH){1'b0}}, flag_reg};
         else if (enable_hit)
            rdata_next = {{(DATA_W-NUM_CH){1'b0}}, enable_reg};
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rdata_reg <= 8'h00;
      else
         rdata_reg <= rdata_next;
   end

   assign rdata = rdata_reg;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   property p_ctrl_indep;
      bus_req.wr && ctrl_hit[0] |=> ctrl_reg[0] == $past(wr_ctrl) && $stable(ctrl_reg[1]);
   endproperty
   a_ctrl_indep: assert property (p_ctrl_indep) else $error("control write leaked");

   property p_on_follow;
      bus_req.wr && ctrl_hit[1] |=> analog_sel[1].comparator_on == $past(wr_ctrl.comparator_on);
   endproperty
   a_on_follow: assert property (p_on_follow) else $error("enable not applied");

   property p_pin_internal;
      !ctrl_reg[0].result_to_pin_enable |=> !result_output_pin[0] && !result_to_pin_enable[0];
   endproperty
   a_pin_internal: assert property (p_pin_internal) else $error("pin driven");

   property p_pin_follow;
      ctrl_reg[0].result_to_pin_enable |=> result_output_pin[0] == $past(adjusted[0]);
   endproperty
   a_pin_follow: assert property (p_pin_follow) else $error("pin value wrong");

   property p_status_invert;
      bus_req.rd && status_hit |=>
         rdata[0] == ($past(synced[0]) ^ $past(ctrl_reg[0].result_invert));
   endproperty
   a_status_invert: assert property (p_status_invert) else $error("status polarity");

   property p_no_event;
      ctrl_reg[1].event_edge_select == EDGE_NONE |-> !event_pulse[1];
   endproperty
   a_no_event: assert property (p_no_event) else $error("event while disabled");

   property p_fall_only;
      event_pulse[0] && ctrl_reg[0].event_edge_select == EDGE_FALL |-> !adjusted[0];
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("falling mode fired");

   property p_auto_set;
      auto_set[0] |=> flag_reg[0];
   endproperty
   a_auto_set: assert property (p_auto_set) else $error("any-change flag missing");

   property p_reserved;
      ctrl_reg[1].negative_input_select == NEG_SECOND_PIN |->
         analog_sel[1].negative_input_select == ROUTE_OPEN;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved route used");

   property p_status_ro;
      bus_req.wr && status_hit |=> $stable(ctrl_reg[0]) && $stable(enable_reg);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status write acted");

   property p_sticky;
      flag_reg[0] && !flag_hit |=> flag_reg[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag dropped");

   property p_unmasked_set;
      event_pulse[1] && !enable_reg[1] |=> flag_reg[1];
   endproperty
   a_unmasked_set: assert property (p_unmasked_set) else $error("masked flag lost");

   property p_sync;
      $past(resetn, 2) |-> synced == $past(comparator_result, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("sync latency wrong");

   c_rise_event: cover property (ctrl_reg[0].event_edge_select == EDGE_RISE && event_pulse[0]);
   c_irq: cover property (event_pulse[1] && enable_reg[1] ##1 irq);
   c_flag_read: cover property (flag_reg[0] && bus_req.rd && flag_hit ##1 !flag_reg[0]);
   c_pin_on: cover property (result_to_pin_enable[1] && result_output_pin[1]);

endmodule

// ### shared/comparator_pkg.sv
/*
 * Shared definitions for the dual comparator control block: register
 * offsets, reset values, control field layout and bus carriers.
 * Assumes an 8-bit register port with 12-bit byte addresses.
 */
package comparator_pkg;

   // ****************************************
   // sizes and offsets
   // ****************************************
   localparam int NUM_CH = 2;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'hf70;
   localparam logic [ADDR_W-1:0] FLAG_OFFSET = 12'hf71;
   localparam logic [ADDR_W-1:0] ENABLE_OFFSET = 12'hf72;
   localparam logic [ADDR_W-1:0] CTRL_SECOND_OFFSET = 12'hfd1;
   localparam logic [ADDR_W-1:0] CTRL_FIRST_OFFSET = 12'hfd2;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h1f;
   localparam logic SYNC_RESET = 1'b1;

   // ****************************************
   // field encodings
   // ****************************************
   typedef enum logic [1:0] {
      EDGE_NONE = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_ANY = 2'h3
   } edge_mode_type;

   typedef enum logic [1:0] {
      NEG_OWN_PIN = 2'h0,
      NEG_RESERVED = 2'h1,
      NEG_SECOND_PIN = 2'h2,
      NEG_FIXED_REF = 2'h3
   } neg_code_type;

   // analog mux route for the inverting input
   typedef enum logic [1:0] {
      ROUTE_OWN_PIN,
      ROUTE_SECOND_PIN,
      ROUTE_FIXED_REF,
      ROUTE_OPEN
   } neg_route_type;

   // control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic comparator_on;
      logic result_to_pin_enable;
      logic result_invert;
      edge_mode_type event_edge_select;
      logic positive_input_select;
      neg_code_type negative_input_select;
   } ctrl_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;

   typedef struct packed {
      logic comparator_on;
      logic positive_input_select;
      neg_route_type negative_input_select;
   } analog_sel_type;

endpackage

// ### rtl/result_sync.sv
/*
 * Two-flop synchroniser for the comparator results.
 * Assumes the inputs may change at any time relative to core_clk.
 */
`timescale 1ns/1ns
module result_sync import comparator_pkg::*; #(
   parameter int WIDTH = NUM_CH
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_reg;
   logic [WIDTH-1:0] stage_next;
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] out_next;

   // first stage feeds only the second
   always_comb
   begin
      stage_next = async_in;
      out_next = stage_reg;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage_reg <= {WIDTH{SYNC_RESET}};
         out_reg <= {WIDTH{SYNC_RESET}};
      end
      else
      begin
         stage_reg <= stage_next;
         out_reg <= out_next;
      end
   end

   assign sync_out = out_reg;

endmodule

// ### rtl/channel_event.sv
/*
 * Per-channel polarity adjust and edge event detection.
 * Assumes a synchronised result and control fields from registers.
 */
`timescale 1ns/1ns
module channel_event import comparator_pkg::*; (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic synced_result,
   input wire logic result_invert,
   input edge_mode_type event_edge_select,
   output logic adjusted_result,
   output logic event_pulse
);

   logic prev_reg;
   logic prev_next;
   logic rise;
   logic fall;

   // inversion sits ahead of status, pin and events
   assign adjusted_result = synced_result ^ result_invert;
   assign rise = adjusted_result & ~prev_reg;
   assign fall = ~adjusted_result & prev_reg;

   // event select per edge mode
   always_comb
   begin
      prev_next = adjusted_result;
      unique case (event_edge_select)
         EDGE_NONE: event_pulse = 1'b0;
         EDGE_RISE: event_pulse = rise;
         EDGE_FALL: event_pulse = fall;
         EDGE_ANY: event_pulse = rise | fall;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         prev_reg <= SYNC_RESET;
      else
         prev_reg <= prev_next;
   end

endmodule

// ### tb/analog_core_model.sv
/*
 * Behavioural model of the two analog comparator cores and their input muxes.
 * Assumes the bench drives input levels in millivolts and the block drives analog_sel.
 */
`timescale 1ns/1ns
module analog_core_model import comparator_pkg::*; (
   input analog_sel_type [NUM_CH-1:0] analog_sel,
   input int pos_pin [NUM_CH],
   input int neg_pin [NUM_CH],
   input int prog_ref,
   input int fixed_ref,
   output logic [NUM_CH-1:0] comparator_result
);

   // ****************************************
   // input muxes and comparison
   // ****************************************
   logic [NUM_CH-1:0] raw;
   int vp;
   int vn;

   // pick both inputs, compare; an open input gives no drive, so low
   always @*
   begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
         vp = analog_sel[ch].positive_input_select ? prog_ref : pos_pin[ch];
         case (analog_sel[ch].negative_input_select)
            ROUTE_OWN_PIN: vn = neg_pin[ch];
            ROUTE_SECOND_PIN: vn = neg_pin[1];
            ROUTE_FIXED_REF: vn = fixed_ref;
            default: vn = vp;
         endcase
         raw[ch] = analog_sel[ch].comparator_on && (vp > vn);
      end
   end

   // core response delay, unrelated to the clock
   assign #13 comparator_result = raw;

endmodule

// ### tb/dual_comparator_control_tb.sv
/*
 * Self-checking bench for the dual comparator control block.
 * Assumes the analog core model on the far side and a 10 MHz core_clk.
 */
`timescale 1ns/1ns
module dual_comparator_control_tb import comparator_pkg::*;;

   // ****************************************
   // signals
   // ****************************************
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   bus_req_type bus_req = '0;
   logic [DATA_W-1:0] rdata;
   logic [NUM_CH-1:0] comparator_result;
   analog_sel_type [NUM_CH-1:0] analog_sel;
   logic [NUM_CH-1:0] result_output_pin;
   logic [NUM_CH-1:0] result_to_pin_enable;
   logic irq;
   int pos_pin [NUM_CH] = '{20, 20};
   int neg_pin [NUM_CH] = '{50, 50};
   int prog_ref = 40;
   int fixed_ref = 60;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [DATA_W-1:0] d;
   neg_route_type route_second [4] = '{ROUTE_OWN_PIN, ROUTE_OPEN, ROUTE_OPEN, ROUTE_FIXED_REF};

   always #50 core_clk = ~core_clk;

   dual_comparator_control DUT (
      .core_clk(core_clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
      .comparator_result(comparator_result), .analog_sel(analog_sel),
      .result_output_pin(result_output_pin), .result_to_pin_enable(result_to_pin_enable),
      .irq(irq)
   );

   analog_core_model cores (
      .analog_sel(analog_sel), .pos_pin(pos_pin), .neg_pin(neg_pin),
      .prog_ref(prog_ref), .fixed_ref(fixed_ref), .comparator_result(comparator_result)
   );

   // ****************************************
   // bus and compare tasks
   // ****************************************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge core_clk);
      bus_req.addr <= a;
      bus_req.wdata <= v;
      bus_req.wr <= 1'b1;
      @(posedge core_clk);
      bus_req.wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge core_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge core_clk);
      bus_req.rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      rd(a, d);
      chk(what, exp, d);
   endtask

   // wait until a level change has crossed the synchroniser and flag stage
   task automatic settle();
      repeat (5) @(posedge core_clk);
      #1;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      settle();
      rd(FLAG_OFFSET, d);
      rd_chk("ctrl first", CTRL_FIRST_OFFSET, 8'h1f);
      rd_chk("ctrl second", CTRL_SECOND_OFFSET, 8'h1f);
      rd_chk("flags", FLAG_OFFSET, 8'h00);
      rd_chk("unmapped", 12'h000, 8'h00);
      chk("irq idle", 8'h00, {7'h0, irq});
   endtask

   task automatic t_auto_set();
      wr(CTRL_FIRST_OFFSET, 8'h80);
      wr(CTRL_FIRST_OFFSET, 8'h98);
      chk("on first", 8'h01, {7'h0, analog_sel[0].comparator_on});
      rd_chk("flag auto", FLAG_OFFSET, 8'h01);
      rd_chk("flag cleared", FLAG_OFFSET, 8'h00);
      rd_chk("ctrl second kept", CTRL_SECOND_OFFSET, 8'h1f);
   endtask

   task automatic t_status();
      wr(CTRL_FIRST_OFFSET, 8'ha0);
      wr(CTRL_SECOND_OFFSET, 8'h83);
      pos_pin[0] = 80;
      pos_pin[1] = 90;
      settle();
      rd_chk("status invert", STATUS_OFFSET, 8'h02);
      wr(STATUS_OFFSET, 8'hff);
      rd_chk("status ro", STATUS_OFFSET, 8'h02);
      wr(CTRL_FIRST_OFFSET, 8'h80);
      settle();
      rd_chk("status plain", STATUS_OFFSET, 8'h03);
      pos_pin[1] = 30;
      settle();
      rd_chk("status second low", STATUS_OFFSET, 8'h01);
   endtask

   task automatic t_edges();
      for (int m = 0; m < 4; m++)
      begin
         pos_pin[0] = 20;
         wr(CTRL_FIRST_OFFSET, {3'b110, 2'(m), 3'b000});
         settle();
         rd(FLAG_OFFSET, d);
         pos_pin[0] = 80;
         settle();
         rd_chk("rise flag", FLAG_OFFSET, {7'h0, m == 1 || m == 3});
         chk("pin high", 8'h03, {6'h0, result_to_pin_enable[0], result_output_pin[0]});
         pos_pin[0] = 20;
         settle();
         rd_chk("fall flag", FLAG_OFFSET, {7'h0, m == 2 || m == 3});
      end
      wr(CTRL_FIRST_OFFSET, 8'hf0);
      settle();
      rd(FLAG_OFFSET, d);
      pos_pin[0] = 80;
      settle();
      rd_chk("inverted fall flag", FLAG_OFFSET, 8'h01);
      chk("pin inverted", 8'h00, {7'h0, result_output_pin[0]});
      wr(CTRL_FIRST_OFFSET, 8'h80);
      settle();
      chk("pin internal", 8'h00, {6'h0, result_to_pin_enable[0], result_output_pin[0]});
   endtask

   task automatic t_irq();
      wr(CTRL_FIRST_OFFSET, 8'h88);
      pos_pin[0] = 20;
      settle();
      rd(FLAG_OFFSET, d);
      wr(ENABLE_OFFSET, 8'h00);
      pos_pin[0] = 80;
      settle();
      chk("irq masked", 8'h00, {7'h0, irq});
      wr(ENABLE_OFFSET, 8'h01);
      chk("irq unmasked", 8'h01, {7'h0, irq});
      rd_chk("flag sticky", FLAG_OFFSET, 8'h01);
      chk("irq cleared", 8'h00, {7'h0, irq});
      wr(FLAG_OFFSET, 8'h02);
      chk("irq other masked", 8'h00, {7'h0, irq});
      wr(ENABLE_OFFSET, 8'h03);
      chk("irq simulated", 8'h01, {7'h0, irq});
      rd_chk("flag simulated", FLAG_OFFSET, 8'h02);
   endtask

   task automatic t_routes();
      for (int c = 0; c < 4; c++)
      begin
         wr(CTRL_SECOND_OFFSET, {6'h0, 2'(c)});
         chk("route second", 8'(route_second[c]),
             8'(analog_sel[1].negative_input_select));
         chk("off second", 8'h00, {7'h0, analog_sel[1].comparator_on});
      end
      wr(CTRL_FIRST_OFFSET, 8'h86);
      chk("route first", 8'(ROUTE_SECOND_PIN), 8'(analog_sel[0].negative_input_select));
      chk("on prog ref", 8'h03,
          {6'h0, analog_sel[0].comparator_on, analog_sel[0].positive_input_select});
      wr(CTRL_FIRST_OFFSET, 8'h01);
      chk("route reserved", 8'(ROUTE_OPEN), 8'(analog_sel[0].negative_input_select));
      chk("pin ref", 8'h00, {7'h0, analog_sel[0].positive_input_select});
   endtask

   // ****************************************
   // verdict, timeout and main sequence
   // ****************************************
   task automatic end_of_test();
      if (n_mismatch == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         n_mismatch++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset();
      t_auto_set();
      t_status();
      t_edges();
      t_irq();
      t_routes();
      end_of_test();
   end

endmodule
